// ==== inc/lfs_pkg.sv ====
// Shared constants and types for the LED fault supervisor.
// Assumes a single 100 MHz clock and a 32-bit Avalon-MM register bus.
package lfs_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int LFS_CH = 4;            // LED channels
  localparam int LFS_CNT_N = 5;         // Four short counters plus one output-short
  localparam int LFS_CNT_W = 16;        // Debounce counter width
  localparam int LFS_PIN_W = 22;        // Synchronised pin bundle width
  localparam int LFS_ST_W = 15;         // Status and interrupt layout width

  // Terminal count of debounce counters (32770 switching cycles)
  localparam logic [15:0] LFS_TERM_COUNT = 16'h8002;

  // ----------------------------------------------------------------
  // Pin bundle positions
  // ----------------------------------------------------------------
  localparam int LFS_P_CHLOW = 0;       // Channel pin at or below 0.3V, 4 bits
  localparam int LFS_P_CHHIGH = 4;      // Channel pin at or above 4.7V, 4 bits
  localparam int LFS_P_FBOPEN = 8;      // Divider input at or above 1.7V
  localparam int LFS_P_FBSHORT = 9;     // Divider input at or below 1.6V
  localparam int LFS_P_FBOVER = 10;     // Divider input above 2.0V
  localparam int LFS_P_FBREL = 11;      // Divider input below 1.45V
  localparam int LFS_P_REGLOW = 12;     // Regulator below 4.3V
  localparam int LFS_P_REGHIGH = 13;    // Regulator above 4.5V
  localparam int LFS_P_OTHOT = 14;      // Die above 175 C
  localparam int LFS_P_OTCOOL = 15;     // Die below 150 C
  localparam int LFS_P_CSLOW = 16;      // Current sense below supply minus 0.6V
  localparam int LFS_P_PWM = 17;        // Brightness input
  localparam int LFS_P_EN = 18;         // Enable input
  localparam int LFS_P_SW = 19;         // Converter switching clock
  localparam int LFS_P_SYSPIN = 20;     // System fault pin level
  localparam int LFS_P_LEDPIN = 21;     // LED fault pin level

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] LFS_OFS_CTRL = 4'h0;
  localparam logic [3:0] LFS_OFS_STATUS = 4'h4;
  localparam logic [3:0] LFS_OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] LFS_OFS_IRQ_MASK = 4'hc;

  // Status fields
  localparam int LFS_ST_OPEN = 0;       // 4 bits
  localparam int LFS_ST_SHORT = 4;      // 4 bits
  localparam int LFS_ST_SCP = 8;
  localparam int LFS_ST_UNDERVOLTAGE_LOCKOUT = 9;
  localparam int LFS_ST_TSD = 10;
  localparam int LFS_ST_OVP = 11;
  localparam int LFS_ST_OCP = 12;
  localparam int LFS_ST_SYSPIN = 13;
  localparam int LFS_ST_LEDPIN = 14;

  // Reset values
  localparam logic LFS_CTRL_PWM_RST = 1'b1;              // Short check gated by brightness
  localparam logic [14:0] LFS_MASK_RST = 15'h0000;
  localparam logic LFS_UNDERVOLTAGE_LOCKOUT_RST = 1'b1;                  // Locked out until regulator is up

  // Bus answer states, Gray order
  typedef enum logic [1:0] {
    LFS_BUS_IDLE = 2'b00,
    LFS_BUS_ANS = 2'b01
  } lfs_bus_t;

  // Bits that have just risen
  function automatic logic [14:0] lfsRise(input logic [14:0] prev, input logic [14:0] cur);
    return cur & ~prev;
  endfunction : lfsRise

endpackage : lfs_pkg

// ==== inc/lfs_cnt_if.sv ====
// Carrier between the supervisor and its debounce counter bank.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface lfs_cnt_if;
  logic tick;                // One-cycle pulse per switching period
  logic [4:0] run;           // Condition present; low clears the counter
  logic [4:0] hold;          // Freeze count while condition is ignored
  logic [4:0] done;          // Terminal count reached

  modport ctrl (output tick, output run, output hold, input done);
  modport bank (input tick, input run, input hold, output done);
endinterface : lfs_cnt_if

// ==== rtl/lfs_debounce_bank.sv ====
// Bank of five debounce counters advanced by the switching tick.
// Assumes tick is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
module lfs_debounce_bank #(
  parameter logic [15:0] TERM = lfs_pkg::LFS_TERM_COUNT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Counter controls
  lfs_cnt_if.bank cnt
);

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  logic [lfs_pkg::LFS_CNT_W-1:0] count_q [lfs_pkg::LFS_CNT_N];  // Count per source

  // Counters step, hold or clear
  always_ff @(posedge clock) begin
    for (int i = 0; i < lfs_pkg::LFS_CNT_N; i++) begin
      if (rst) begin
        count_q[i] <= '0;
      end else if (!cnt.run[i]) begin
        count_q[i] <= '0;
      end else if (cnt.hold[i]) begin
        count_q[i] <= count_q[i];
      end else if (cnt.tick && count_q[i] != TERM) begin
        count_q[i] <= count_q[i] + 16'h0001;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < lfs_pkg::LFS_CNT_N; i++) begin
      cnt.done[i] = cnt.run[i] && (count_q[i] == TERM);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  cnt_clear_a: assert property (!cnt.run[0] |=> count_q[0] == '0)
    else $error("counter not cleared on release");
  cnt_step_a: assert property (cnt.run[1] && !cnt.hold[1] && cnt.tick && count_q[1] != TERM
    ##1 cnt.run[1] |-> count_q[1] == $past(count_q[1]) + 16'h0001)
    else $error("counter did not step");
  cnt_tick_a: assert property (cnt.run[4] && !cnt.tick ##1 cnt.run[4]
    |-> count_q[4] == $past(count_q[4]))
    else $error("counter moved without tick");
  cnt_cap_a: assert property (count_q[2] <= TERM)
    else $error("counter past terminal");

endmodule : lfs_debounce_bank

// ==== rtl/lfs_supervisor.sv ====
// Fault supervision for a four-channel LED driver with switching converter.
// Assumes comparator flags and pins are asynchronous; Avalon-MM master on clock.
//
// Functional notes
// - Low pin with high divider latches open
// - High pin, low divider starts short counter
// - Short check only while brightness input high
// - Released condition clears the short counter
// - Counters advance once per switching cycle
// - Latch fault at count 32770
// - Lockout below 4.3V until above 4.5V
// - Overtemperature stops all but regulator, hysteresis
// - Overvoltage discharges soft-start, pulls system fault
// - Low channel pin runs output-short latch-off counter
// - Latches hold until enable low or lockout
// - Open channel turned off, LED fault low
// - System fault on lockout, heat, overvoltage, output short
// - LED fault on any open or short
// - Low current sense discharges, stops switching (code only raises ssDischarge, no shutdown output)
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module lfs_supervisor #(
  parameter logic [15:0] TERM = lfs_pkg::LFS_TERM_COUNT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // Comparator flags
  input wire logic [3:0] chLowIn,
  input wire logic [3:0] chHighIn,
  input wire logic fbOpenIn,
  input wire logic fbShortIn,
  input wire logic fbOverIn,
  input wire logic fbReleaseIn,
  input wire logic regLowIn,
  input wire logic regHighIn,
  input wire logic hotIn,
  input wire logic coolIn,
  input wire logic senseLowIn,
  // Control pins
  input wire logic pwmIn,
  input wire logic enableIn,
  input wire logic switchClkIn,
  // Open-drain fault pins
  input wire logic systemFaultNI,
  output logic systemFaultNO,
  output logic systemFaultNOe,
  input wire logic ledFaultNI,
  output logic ledFaultNO,
  output logic ledFaultNOe,
  // Power stage controls
  output logic [3:0] channelOff,
  output logic shutdownAll,
  output logic shutdownMost,
  output logic ssDischarge,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [21:0] pinRaw;       // Raw pin bundle
  logic [21:0] pinS1_q;      // First stage
  logic [21:0] pinS2_q;      // Second stage
  logic [21:0] pinS3_q;      // Third stage
  logic [21:0] pinF_q;       // Accepted level
  logic [21:0] agree;        // Second and third stage match

  assign pinRaw = {ledFaultNI, systemFaultNI, switchClkIn, enableIn, pwmIn, senseLowIn,
                   coolIn, hotIn, regHighIn, regLowIn, fbReleaseIn, fbOverIn,
                   fbShortIn, fbOpenIn, chHighIn, chLowIn};
  assign agree = ~(pinS2_q ^ pinS3_q);

  // Three-stage chain, level taken once stages two and three agree
  always_ff @(posedge clock) begin
    if (rst) begin
      pinS1_q <= '0;
      pinS2_q <= '0;
      pinS3_q <= '0;
      pinF_q <= '0;
    end else begin
      pinS1_q <= pinRaw;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinF_q <= (pinF_q & ~agree) | (pinS2_q & agree);
    end
  end

  // Named views of accepted levels
  logic [3:0] chLow;
  logic [3:0] chHigh;
  logic enOn;
  assign chLow = pinF_q[lfs_pkg::LFS_P_CHLOW +: 4];
  assign chHigh = pinF_q[lfs_pkg::LFS_P_CHHIGH +: 4];
  // enable taken as given after supply
  assign enOn = pinF_q[lfs_pkg::LFS_P_EN];

  // ----------------------------------------------------------------
  // Protection states
  // ----------------------------------------------------------------
  logic undervoltage_lockout_q;              // Undervoltage lockout
  logic tsd_q;               // Thermal shutdown
  logic ovp_q;               // Overvoltage
  logic ocp_q;               // Overcurrent
  logic scp_q;               // Output-short latch
  logic [3:0] openLat_q;     // Open latch per channel
  logic [3:0] shortLat_q;    // Short latch per channel
  logic ctrlPwm_q;           // Brightness gating enable
  logic swPrev_q;            // Previous switching level
  logic latchClr;            // Latch clear term
  logic active;              // Detection allowed

  assign latchClr = !enOn || undervoltage_lockout_q;
  assign active = !latchClr && !tsd_q && !scp_q;

  // Hysteresis step: detect flag sets and wins, release flag clears, else hold
  function automatic logic hystStep(input logic cur, input logic setF, input logic relF);
    return setF ? 1'b1 : (relF ? 1'b0 : cur);
  endfunction : hystStep
  // Protection levels, one detect and one release threshold each except overcurrent, which follows its flag
  always_ff @(posedge clock) begin
    if (rst) begin
      undervoltage_lockout_q <= lfs_pkg::LFS_UNDERVOLTAGE_LOCKOUT_RST;
      tsd_q <= 1'b0;
      ovp_q <= 1'b0;
      ocp_q <= 1'b0;
    end else begin
      undervoltage_lockout_q <= hystStep(undervoltage_lockout_q, pinF_q[lfs_pkg::LFS_P_REGLOW], pinF_q[lfs_pkg::LFS_P_REGHIGH]);
      tsd_q <= hystStep(tsd_q, pinF_q[lfs_pkg::LFS_P_OTHOT], pinF_q[lfs_pkg::LFS_P_OTCOOL]);
      ovp_q <= hystStep(ovp_q, pinF_q[lfs_pkg::LFS_P_FBOVER], pinF_q[lfs_pkg::LFS_P_FBREL]);
      ocp_q <= pinF_q[lfs_pkg::LFS_P_CSLOW];
    end
  end

  // Switching clock edge for tick
  always_ff @(posedge clock) begin
    if (rst) begin
      swPrev_q <= 1'b0;
    end else begin
      swPrev_q <= pinF_q[lfs_pkg::LFS_P_SW];
    end
  end

  // ----------------------------------------------------------------
  // Debounce counters
  // ----------------------------------------------------------------
  lfs_cnt_if cnt ();
  // one tick per switching rising edge
  assign cnt.tick = pinF_q[lfs_pkg::LFS_P_SW] && !swPrev_q;
  // Counter run and hold terms
  always_comb begin
    for (int i = 0; i < lfs_pkg::LFS_CH; i++) begin
      cnt.run[i] = active && chHigh[i] && pinF_q[lfs_pkg::LFS_P_FBSHORT]
                   && !openLat_q[i] && !shortLat_q[i];
      cnt.hold[i] = ctrlPwm_q && !pinF_q[lfs_pkg::LFS_P_PWM];
    end
    cnt.run[4] = active && ((chLow & ~openLat_q & ~shortLat_q) != 4'h0);
    cnt.hold[4] = 1'b0;
  end

  lfs_debounce_bank #(
    .TERM(TERM)
  ) uBank (
    .clock(clock),
    .rst(rst),
    .cnt(cnt.bank)
  );

  // ----------------------------------------------------------------
  // Fault latches
  // ----------------------------------------------------------------
  // Fault latches, all dropped together by the latch clear term
  always_ff @(posedge clock) begin
    if (rst || latchClr) begin
      openLat_q <= 4'h0;
      shortLat_q <= 4'h0;
      scp_q <= 1'b0;
    end else begin
      if (active) begin
        openLat_q <= openLat_q | (chLow & {4{pinF_q[lfs_pkg::LFS_P_FBOPEN]}} & ~shortLat_q);
      end
      // independent short latch at terminal count
      shortLat_q <= shortLat_q | cnt.done[3:0];
      scp_q <= scp_q | cnt.done[4];
    end
  end
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Power stage and pin drives
  always_ff @(posedge clock) begin
    if (rst) begin
      channelOff <= 4'hf;
      shutdownAll <= 1'b1;
      shutdownMost <= 1'b0;
      ssDischarge <= 1'b1;
      systemFaultNO <= 1'b0;
      systemFaultNOe <= 1'b0;
      ledFaultNO <= 1'b0;
      ledFaultNOe <= 1'b0;
    end else begin
      channelOff <= openLat_q | shortLat_q | {4{!enOn || undervoltage_lockout_q || tsd_q || scp_q}};
      shutdownAll <= undervoltage_lockout_q;
      shutdownMost <= tsd_q || scp_q;
      ssDischarge <= ovp_q || ocp_q || undervoltage_lockout_q || tsd_q || scp_q;
      systemFaultNO <= 1'b0;
      systemFaultNOe <= undervoltage_lockout_q || tsd_q || ovp_q || scp_q;
      ledFaultNO <= 1'b0;
      ledFaultNOe <= (openLat_q | shortLat_q) != 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupts
  // ----------------------------------------------------------------
  logic [14:0] status;       // Live status word
  logic [14:0] stPrev_q;     // Previous status
  logic [14:0] irqStat_q;    // Sticky events
  logic [14:0] irqMask_q;    // Interrupt mask
  logic [14:0] w1c;          // Bits cleared by write
  lfs_pkg::lfs_bus_t busState_q;
  logic wrTake;              // Write takes effect

  assign status = {!pinF_q[lfs_pkg::LFS_P_LEDPIN], !pinF_q[lfs_pkg::LFS_P_SYSPIN], ocp_q,
                   ovp_q, tsd_q, undervoltage_lockout_q, scp_q, shortLat_q, openLat_q};
  assign wrTake = (busState_q == lfs_pkg::LFS_BUS_ANS) && avsWrite;
  assign w1c = (wrTake && avsAddress == lfs_pkg::LFS_OFS_IRQ_STAT)
               ? (avsWriteData[14:0] & {{7{avsByteEnable[1]}}, {8{avsByteEnable[0]}}})
               : 15'h0000;

  // Sticky events, set wins over clear; level interrupt from stored bits
  always_ff @(posedge clock) begin
    if (rst) begin
      stPrev_q <= status;    // Track live word, so release shows no false edge
      irqStat_q <= 15'h0000;
      irq <= 1'b0;
    end else begin
      stPrev_q <= status;
      irqStat_q <= (irqStat_q & ~w1c) | lfs_pkg::lfsRise(stPrev_q, status);
      irq <= (irqStat_q & irqMask_q) != 15'h0000;
    end
  end

  // Control and mask writes
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrlPwm_q <= lfs_pkg::LFS_CTRL_PWM_RST;
      irqMask_q <= lfs_pkg::LFS_MASK_RST;
    end else if (wrTake) begin
      if (avsAddress == lfs_pkg::LFS_OFS_CTRL && avsByteEnable[0]) begin
        ctrlPwm_q <= avsWriteData[0];
      end
      if (avsAddress == lfs_pkg::LFS_OFS_IRQ_MASK) begin
        if (avsByteEnable[0]) begin
          irqMask_q[7:0] <= avsWriteData[7:0];
        end
        if (avsByteEnable[1]) begin
          irqMask_q[14:8] <= avsWriteData[14:8];
        end
      end
    end
  end

  // Read decode
  function automatic logic [31:0] readMux(input logic [3:0] adr, input logic pwmEn,
                                          input logic [14:0] st, input logic [14:0] ist,
                                          input logic [14:0] msk);
    case (adr)
      lfs_pkg::LFS_OFS_CTRL: return {31'h0, pwmEn};
      lfs_pkg::LFS_OFS_STATUS: return {17'h0, st};
      lfs_pkg::LFS_OFS_IRQ_STAT: return {17'h0, ist};
      lfs_pkg::LFS_OFS_IRQ_MASK: return {17'h0, msk};
      default: return 32'h0;
    endcase
  endfunction : readMux

  // Bus answer: one wait cycle, then waitrequest low for one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      busState_q <= lfs_pkg::LFS_BUS_IDLE;
      avsWaitRequest <= 1'b1;
      avsReadData <= 32'h0;
    end else begin
      case (busState_q)
        lfs_pkg::LFS_BUS_IDLE: begin
          if (avsRead || avsWrite) begin
            busState_q <= lfs_pkg::LFS_BUS_ANS;
            avsWaitRequest <= 1'b0;
            avsReadData <= readMux(avsAddress, ctrlPwm_q, status, irqStat_q, irqMask_q);
          end
        end
        lfs_pkg::LFS_BUS_ANS: begin
          busState_q <= lfs_pkg::LFS_BUS_IDLE;
          avsWaitRequest <= 1'b1;
        end
        default: begin
          busState_q <= lfs_pkg::LFS_BUS_IDLE;
          avsWaitRequest <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  open_latch_a: assert property (active && chLow[0] && pinF_q[lfs_pkg::LFS_P_FBOPEN]
    && !shortLat_q[0] |=> openLat_q[0])
    else $error("open not latched");
  pwm_hold_a: assert property (ctrlPwm_q && !pinF_q[lfs_pkg::LFS_P_PWM]
    |-> cnt.hold[0] && cnt.hold[3])
    else $error("short check not ignored");
  short_latch_a: assert property (cnt.done[2] && !latchClr |=> shortLat_q[2]
    ##1 channelOff[2])
    else $error("short not latched");
  scp_latch_a: assert property (cnt.done[4] && !latchClr |=> scp_q
    ##1 shutdownMost && systemFaultNOe)
    else $error("output short not latched");
  undervoltage_lockout_hold_a: assert property (undervoltage_lockout_q && !pinF_q[lfs_pkg::LFS_P_REGHIGH]
    |=> undervoltage_lockout_q ##1 shutdownAll)
    else $error("lockout released early");
  tsd_stop_a: assert property ($rose(tsd_q) |=> shutdownMost && channelOff == 4'hf)
    else $error("heat shutdown missing");
  ovp_fault_a: assert property (ovp_q |=> ssDischarge && systemFaultNOe)
    else $error("overvoltage not acted on");
  latch_keep_a: assert property (openLat_q[1] && !latchClr |=> openLat_q[1])
    else $error("open latch lost");
  open_out_a: assert property (openLat_q[0] |=> channelOff[0] && ledFaultNOe)
    else $error("open channel not off");
  ocp_stop_a: assert property (ocp_q |=> ssDischarge)
    else $error("overcurrent not acted on");
  bus_ans_a: assert property ((avsRead || avsWrite) && avsWaitRequest
    |=> !avsWaitRequest ##1 avsWaitRequest)
    else $error("bus answer timing");

  open_seen_c: cover property (active ##1 $rose(openLat_q != 4'h0));
  short_seen_c: cover property ($rose(shortLat_q != 4'h0));
  irq_seen_c: cover property ($rose(irq) ##[1:50] !irq);

endmodule : lfs_supervisor

// ==== bench/lfs_led_model.sv ====
// Model of the LED strings, divider, regulator and thermal comparators.
// Assumes the bench changes the modes just after rising clock edges.
`timescale 1ns/1ps
module lfs_led_model (
  // Clock
  input wire logic clock,
  // Scenario modes: per channel 0 ok, 1 pin low, 2 pin high
  input wire logic [7:0] ledMode,
  input wire logic [1:0] fbLvl,
  input wire logic regOk,
  input wire logic tempHot,
  // Comparator flags
  output logic [3:0] chLow,
  output logic [3:0] chHigh,
  output logic fbOpen,
  output logic fbShort,
  output logic fbOver,
  output logic fbRel,
  output logic regLow,
  output logic regHigh,
  output logic hot,
  output logic cool,
  output logic swClk,
  // Open-drain fault pins
  input wire logic sysNOe,
  input wire logic ledNOe,
  output logic sysPin,
  output logic ledPin
);
  logic [2:0] swCnt_q = 3'h0; // Switching clock divider
  // Divider codes: 0 is 1.0V, 1 is 1.8V, 2 is 2.2V
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      chLow[i] = ledMode[2*i+:2] == 2'h1;
      chHigh[i] = ledMode[2*i+:2] == 2'h2;
    end
  end
  assign fbOpen = fbLvl != 2'h0;
  assign fbShort = fbLvl == 2'h0;
  assign fbOver = fbLvl == 2'h2;
  assign fbRel = fbLvl == 2'h0;
  assign regLow = !regOk;
  assign regHigh = regOk;
  assign hot = tempHot;
  assign cool = !tempHot;
  // Free-running converter clock, four cycles high and four low
  always_ff @(posedge clock) swCnt_q <= swCnt_q + 3'h1;
  assign swClk = swCnt_q[2];
  // Pull-ups hold released pins high
  assign sysPin = sysNOe ? 1'h0 : 1'h1;
  assign ledPin = ledNOe ? 1'h0 : 1'h1;
endmodule : lfs_led_model

// ==== bench/led_fault_supervisor_tb.sv ====
// Self-checking bench for the LED fault supervisor.
// Assumes the LED model file is compiled first; short count shrunk to 8.
`timescale 1ns/1ps
module led_fault_supervisor_tb;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'h0, avsWrite = 1'h0, pwmIn = 1'h1, enableIn = 1'h0, senseLowIn = 1'h0;
  logic [31:0] avsWriteData = 32'h0, avsReadData, rdat;
  logic [3:0] chLowIn, chHighIn, channelOff;
  logic fbOpenIn, fbShortIn, fbOverIn, fbReleaseIn, regLowIn, regHighIn, hotIn, coolIn;
  logic switchClkIn, avsWaitRequest, systemFaultNI, systemFaultNO, systemFaultNOe;
  logic ledFaultNI, ledFaultNO, ledFaultNOe, shutdownAll, shutdownMost, ssDischarge, irq;
  logic [7:0] ledMode = 8'h0;
  logic [1:0] fbLvl = 2'h1;
  logic regOk = 1'h0, tempHot = 1'h0;
  int n_fail = 0, tests_run = 0;
  always #5 clock = ~clock;
  lfs_supervisor #(.TERM(16'h0008)) lfs_supervisor_inst (.clock, .rst, .avsAddress, .avsRead,
    .avsWrite, .avsWriteData, .avsByteEnable(4'hf), .avsReadData, .avsWaitRequest, .chLowIn,
    .chHighIn, .fbOpenIn, .fbShortIn, .fbOverIn, .fbReleaseIn, .regLowIn, .regHighIn, .hotIn,
    .coolIn, .senseLowIn, .pwmIn, .enableIn, .switchClkIn, .systemFaultNI, .systemFaultNO,
    .systemFaultNOe, .ledFaultNI, .ledFaultNO, .ledFaultNOe, .channelOff, .shutdownAll,
    .shutdownMost, .ssDischarge, .irq);
  lfs_led_model lfs_led_model_inst (.clock, .ledMode, .fbLvl, .regOk, .tempHot, .chLow(chLowIn),
    .chHigh(chHighIn), .fbOpen(fbOpenIn), .fbShort(fbShortIn), .fbOver(fbOverIn),
    .fbRel(fbReleaseIn), .regLow(regLowIn), .regHigh(regHighIn), .hot(hotIn), .cool(coolIn),
    .swClk(switchClkIn), .sysNOe(systemFaultNOe), .ledNOe(ledFaultNOe), .sysPin(systemFaultNI),
    .ledPin(ledFaultNI));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avsRead <= !w;
    avsWrite <= w;
    avsAddress <= a;
    avsWriteData <= d;
    // Hold the request until waitrequest is sampled low at a rising edge
    do @(posedge clock); while (avsWaitRequest !== 1'h0);
    rdat = avsReadData;
    avsRead <= 1'h0;
    avsWrite <= 1'h0;
  endtask : bus
  // Enable cycled low to clear latches
  task automatic clr;
    ledMode <= 8'h0;
    enableIn <= 1'h0;
    cyc(10);
    enableIn <= 1'h1;
    cyc(10);
  endtask : clr
  task automatic t_open;
    ledMode <= 8'h10;
    bus(1'h1, 4'hc, 32'h4);
    cyc(10);
    chk("chOff", 32'h4, channelOff);
    chk("ledFlt", 32'h1, ledFaultNOe);
    chk("irq", 32'h1, irq);
    chk("sysNO", 32'h0, systemFaultNO);
    chk("ledNO", 32'h0, ledFaultNO);
    bus(1'h0, 4'h4, 32'h0);
    chk("status", 32'h4004, rdat);
    bus(1'h1, 4'h8, 32'h4);
    cyc(3);
    chk("irq", 32'h0, irq);
    ledMode <= 8'h0;
    cyc(10);
    chk("chOff", 32'h4, channelOff);
    clr();
    chk("chOff", 32'h0, channelOff);
  endtask : t_open
  task automatic t_short;
    fbLvl <= 2'h0;
    pwmIn <= 1'h0;
    ledMode <= 8'h08;
    cyc(200);
    chk("chOff", 32'h0, channelOff);
    pwmIn <= 1'h1;
    cyc(40);
    chk("chOff", 32'h0, channelOff);
    cyc(60);
    chk("chOff", 32'h2, channelOff);
    chk("ledFlt", 32'h1, ledFaultNOe);
    clr();
    ledMode <= 8'h80;
    cyc(48);
    ledMode <= 8'h0;
    cyc(16);
    ledMode <= 8'h80;
    cyc(48);
    chk("chOff", 32'h0, channelOff);
    cyc(50);
    chk("chOff", 32'h8, channelOff);
    clr();
    // Brightness gating off: short counted with brightness input low
    bus(1'h1, 4'h0, 32'h0);
    pwmIn <= 1'h0;
    ledMode <= 8'h80;
    cyc(100);
    chk("chOff", 32'h8, channelOff);
    pwmIn <= 1'h1;
    bus(1'h1, 4'h0, 32'h1);
    clr();
  endtask : t_short
  task automatic t_prot;
    ledMode <= 8'h01;
    cyc(40);
    chk("most", 32'h0, shutdownMost);
    cyc(60);
    chk("most", 32'h1, shutdownMost);
    chk("sysFlt", 32'h1, systemFaultNOe);
    clr();
    chk("most", 32'h0, shutdownMost);
    tempHot <= 1'h1;
    cyc(10);
    chk("most", 32'h1, shutdownMost);
    chk("sysFlt", 32'h1, systemFaultNOe);
    tempHot <= 1'h0;
    cyc(10);
    chk("most", 32'h0, shutdownMost);
    fbLvl <= 2'h2;
    cyc(10);
    chk("ss", 32'h1, ssDischarge);
    chk("sysFlt", 32'h1, systemFaultNOe);
    fbLvl <= 2'h1;
    cyc(10);
    chk("ss", 32'h1, ssDischarge);
    fbLvl <= 2'h0;
    cyc(10);
    chk("ss", 32'h0, ssDischarge);
    senseLowIn <= 1'h1;
    cyc(10);
    chk("ss", 32'h1, ssDischarge);
    senseLowIn <= 1'h0;
    regOk <= 1'h0;
    cyc(10);
    chk("all", 32'h1, shutdownAll);
    chk("sysFlt", 32'h1, systemFaultNOe);
  endtask : t_prot
  task automatic end_of_test;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    cyc(10);
    chk("chOff", 32'hf, channelOff);
    rst <= 1'h0;
    cyc(20);
    chk("all", 32'h1, shutdownAll);
    regOk <= 1'h1;
    cyc(12);
    chk("all", 32'h0, shutdownAll);
    enableIn <= 1'h1;
    cyc(10);
    bus(1'h0, 4'h0, 32'h0);
    chk("ctrl", 32'h1, rdat);
    t_open();
    t_short();
    t_prot();
    end_of_test();
  end
  initial begin
    cyc(5000);
    n_fail++;
    end_of_test();
  end
endmodule : led_fault_supervisor_tb
